// File: burst_sram_consts.svh
// Contract
// R1 - Register inputs and read data on rising edge
// R2 - Burst order follows sampled order select
// R3 - Interleaved: start address XOR beat count
// R4 - Linear: low bits increment, wrap 11 to 00
// R5 - Read: strobe, all selects, no writes
// R6 - Read data appears after next edge
// R7 - Outputs off first cycle after deselect
// R8 - Deselect by strobe tristates outputs at once
// R9 - Processor write: two cycles, first ignores writes
// R10 - Second edge: global write or byte lanes
// R11 - Byte write touches selected lanes only
// R12 - Global write overrides lanes, writes all
// R13 - Controller write completes in one cycle
// R14 - Write cycle forces data lines off
// R15 - Master raises output enable before writing
// R16 - Start bits load burst counter on access
// R17 - Advance low steps burst counter
// R18 - Sleep entered or left within two cycles
// R19 - Accesses pending at sleep are dropped; writes already in the buffer are held and drain after wake
// R20 - Master deselects around sleep and recovery
// R21 - Both strobes: processor strobe wins
// R22 - Depth selects sampled only on address load
// R23 - Order select low means linear order
// R24 - Burst keeps upper address bits fixed
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH
`define ADDR_W      18
`define DATA_W      36
`define LANES       4
`define LANE_W      9
`define BURST_W     2
`define MEM_WORDS   262144
`define WBUF_DEPTH  32
`define WBUF_AW     5
`define ORDER_LINEAR 1'b0
`define LANES_ALL   4'hF
`define LANES_NONE  4'h0
`endif

// File: burst_sram_pkg.sv
`include "burst_sram_consts.svh"
package burst_sram_pkg;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
        logic               pstb_n;
        logic               cstb_n;
        logic               step_n;
        logic               allw_n;
        logic               bytew_n;
        logic [`LANES-1:0]  lanew_n;
        logic               cs1_n;
        logic               cs2;
        logic               cs3_n;
        logic               order;
    } bus_in_s;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`LANES-1:0]  lanes;
        logic [`DATA_W-1:0] data;
    } wr_entry_s;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_SLEEP  = 2'b10
    } port_state_e;
endpackage : burst_sram_pkg

// File: burst_sram_port.sv
`include "burst_sram_consts.svh"

module wbuf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    always_comb begin
        in_ready  = (cnt_r != (AW+1)'(DEPTH));
        out_valid = (cnt_r != '0);
        out_data  = store[rp_r];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_nxt    = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt    = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt   = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            store[wp_r] <= in_data;
        end
    end
endmodule : wbuf_fifo

module burst_sram_port (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic [`ADDR_W-1:0] addr,
    input  wire logic [`DATA_W-1:0] data_io_in,
    output logic      [`DATA_W-1:0] data_io_out,
    output logic                    data_io_oe,
    input  wire logic               processor_addr_strobe_n,
    input  wire logic               controller_addr_strobe_n,
    input  wire logic               burst_advance_n,
    input  wire logic               global_write_n,
    input  wire logic               byte_write_enable_n,
    input  wire logic [`LANES-1:0]  byte_lane_write_n,
    input  wire logic               chip_select_primary_n,
    input  wire logic               chip_select_depth_hi,
    input  wire logic               chip_select_depth_lo_n,
    input  wire logic               burst_order_sel,
    input  wire logic               output_enable_n,
    input  wire logic               sleep_request,
    output logic                    wbuf_ready,
    output logic                    sleeping
);
    localparam int HI = `ADDR_W - `BURST_W;

    function automatic logic [`BURST_W-1:0] burst_low(
        input logic [`BURST_W-1:0] start,
        input logic [`BURST_W-1:0] beat,
        input logic                order
    );
        if (order == `ORDER_LINEAR) begin // R23
            burst_low = `BURST_W'(start + beat); // R4
        end else begin
            burst_low = start ^ beat; // R3
        end
    endfunction : burst_low

    logic [`DATA_W-1:0] mem [0:`MEM_WORDS-1];

    burst_sram_pkg::bus_in_s     in_r, in_nxt;
    burst_sram_pkg::port_state_e st_r, st_nxt;
    burst_sram_pkg::wr_entry_s   wr_entry, drain_entry;
    logic [HI-1:0]        base_r, base_nxt;
    logic [`BURST_W-1:0]  start_r, start_nxt, beat_r, beat_nxt;
    logic [`DATA_W-1:0]   dout_r, dout_nxt;
    logic                 rdv_r, rdv_nxt;
    logic                 zz1_r, zz2_r, oe1_r, oe2_r;
    logic                 active, pstrobe, cstrobe, load, selected;
    logic                 wr_any, rd_op, wcycle, deselect, emerging;
    logic                 wr_push, drain_valid, drain_ready;
    logic [`BURST_W-1:0]  cur_beat;
    logic [`ADDR_W-1:0]   cur_addr;
    logic [`LANES-1:0]    lanes;

    // Input register and asynchronous pin synchronisers
    always_comb begin
        in_nxt.addr   = addr;
        in_nxt.data   = data_io_in;
        in_nxt.pstb_n  = processor_addr_strobe_n;
        in_nxt.cstb_n  = controller_addr_strobe_n;
        in_nxt.step_n  = burst_advance_n;
        in_nxt.allw_n  = global_write_n;
        in_nxt.bytew_n = byte_write_enable_n;
        in_nxt.lanew_n = byte_lane_write_n;
        in_nxt.cs1_n   = chip_select_primary_n;
        in_nxt.cs2     = chip_select_depth_hi;
        in_nxt.cs3_n   = chip_select_depth_lo_n;
        in_nxt.order  = burst_order_sel;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            in_r  <= '{pstb_n: 1'b1, cstb_n: 1'b1, step_n: 1'b1,
                       allw_n: 1'b1, bytew_n: 1'b1, lanew_n: `LANES_ALL,
                       cs1_n: 1'b1, cs3_n: 1'b1, default: '0};
            zz1_r <= 1'b0;
            zz2_r <= 1'b0;
            oe1_r <= 1'b1;
            oe2_r <= 1'b1;
        end else begin
            in_r  <= in_nxt; // R1
            zz1_r <= sleep_request;
            zz2_r <= zz1_r; // R18
            oe1_r <= output_enable_n;
            oe2_r <= oe1_r;
        end
    end

    // Cycle decode from the registered inputs
    always_comb begin
        active   = (st_r == burst_sram_pkg::ST_ACTIVE);
        pstrobe  = !in_r.pstb_n && !in_r.cs1_n && !zz2_r; // R5
        cstrobe  = !in_r.cstb_n && !pstrobe && !zz2_r; // R21
        load     = pstrobe || cstrobe;
        selected = !in_r.cs1_n && in_r.cs2 && !in_r.cs3_n; // R22
        wr_any   = !in_r.allw_n
                   || (!in_r.bytew_n && in_r.lanew_n != `LANES_ALL);
        deselect = load && !selected; // R8
        emerging = load && selected && !active; // R7
        rd_op    = load ? (selected && (pstrobe || !wr_any)) // R5 R9
                        : (active && !wr_any);
        wcycle   = load ? (cstrobe && selected && wr_any) // R13
                        : (active && wr_any); // R9 R10
        if (load) begin
            cur_beat = '0; // R16
        end else if (active && !in_r.step_n) begin
            cur_beat = `BURST_W'(beat_r + 1'b1); // R17
        end else begin
            cur_beat = beat_r;
        end
        if (load) begin
            cur_addr = in_r.addr;
        end else begin
            cur_addr = {base_r, burst_low(start_r, cur_beat, in_r.order)};
        end // R2 R24
        if (!in_r.allw_n) begin
            lanes = `LANES_ALL; // R12
        end else if (!in_r.bytew_n) begin
            lanes = ~in_r.lanew_n; // R11
        end else begin
            lanes = `LANES_NONE;
        end
    end

    // Port state and burst counter
    always_comb begin
        st_nxt    = st_r;
        base_nxt  = base_r;
        start_nxt = start_r;
        beat_nxt  = beat_r;
        case (st_r)
            burst_sram_pkg::ST_IDLE,
            burst_sram_pkg::ST_ACTIVE: begin
                if (zz2_r) begin
                    st_nxt = burst_sram_pkg::ST_SLEEP; // R19
                end else if (load) begin
                    st_nxt = selected ? burst_sram_pkg::ST_ACTIVE
                                      : burst_sram_pkg::ST_IDLE;
                end
            end
            burst_sram_pkg::ST_SLEEP: begin
                if (!zz2_r) begin
                    st_nxt = burst_sram_pkg::ST_IDLE; // R18
                end
            end
            default: st_nxt = burst_sram_pkg::ST_IDLE;
        endcase
        if (load) begin
            base_nxt  = in_r.addr[`ADDR_W-1:`BURST_W]; // R24
            start_nxt = in_r.addr[`BURST_W-1:0]; // R16
        end
        if (load || active) begin
            beat_nxt = cur_beat;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_r    <= burst_sram_pkg::ST_IDLE;
            base_r  <= '0;
            start_r <= '0;
            beat_r  <= '0;
        end else begin
            st_r    <= st_nxt;
            base_r  <= base_nxt;
            start_r <= start_nxt;
            beat_r  <= beat_nxt;
        end
    end

    // Read pipeline and output drive
    always_comb begin
        rdv_nxt  = rd_op && !zz2_r;
        dout_nxt = rd_op ? mem[cur_addr] : dout_r;
        data_io_out = dout_r;
        data_io_oe  = rdv_r && !oe2_r && !wcycle // R14
                      && !deselect && !emerging && !zz2_r; // R7 R8
        sleeping    = (st_r == burst_sram_pkg::ST_SLEEP);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdv_r  <= 1'b0;
            dout_r <= '0;
        end else begin
            rdv_r  <= rdv_nxt; // R6
            dout_r <= dout_nxt; // R1
        end
    end

    // Writes queue in the buffer and drain into the array
    always_comb begin
        wr_push        = wcycle && !zz2_r && lanes != `LANES_NONE;
        wr_entry.addr  = cur_addr;
        wr_entry.lanes = lanes;
        wr_entry.data  = in_r.data;
        drain_ready    = !zz2_r;
    end

    wbuf_fifo #(
        .WIDTH ($bits(burst_sram_pkg::wr_entry_s)),
        .DEPTH (`WBUF_DEPTH),
        .AW    (`WBUF_AW)
    ) u_wbuf (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (wr_push),
        .in_ready  (wbuf_ready),
        .in_data   (wr_entry),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_entry)
    );

    always_ff @(posedge mclk) begin
        if (drain_valid && drain_ready) begin
            for (int i = 0; i < `LANES; i++) begin
                if (drain_entry.lanes[i]) begin // R11
                    mem[drain_entry.addr][i*`LANE_W +: `LANE_W]
                        <= drain_entry.data[i*`LANE_W +: `LANE_W];
                end
            end
        end
    end

    AST_READ_DATA: assert property ( // R6
        @(posedge mclk) disable iff (!rstn)
        (rd_op && !zz2_r) |=> rdv_r && dout_r == $past(mem[cur_addr]))
        else $error("read data not registered after access");
    AST_WRITE_OFF: assert property ( // R14
        @(posedge mclk) disable iff (!rstn) wcycle |-> !data_io_oe)
        else $error("data driven during write cycle");
    AST_DESEL_OFF: assert property ( // R8
        @(posedge mclk) disable iff (!rstn)
        deselect |-> !data_io_oe ##1 !rdv_r)
        else $error("data driven after deselect");
    AST_EMERGE_OFF: assert property ( // R7
        @(posedge mclk) disable iff (!rstn)
        (st_r == burst_sram_pkg::ST_IDLE && load) |-> !data_io_oe)
        else $error("data driven in first selected cycle");
    AST_CNT_LOAD: assert property ( // R16
        @(posedge mclk) disable iff (!rstn)
        (load && selected && !zz2_r) |=>
            start_r == $past(in_r.addr[1:0]) && beat_r == 2'h0
            && st_r == burst_sram_pkg::ST_ACTIVE)
        else $error("burst counter not loaded");
    AST_CNT_STEP: assert property ( // R17
        @(posedge mclk) disable iff (!rstn)
        (active && !load && !in_r.step_n) |=>
            beat_r == 2'($past(beat_r) + 2'h1))
        else $error("burst counter did not step");
    AST_UPPER_HOLD: assert property ( // R24
        @(posedge mclk) disable iff (!rstn)
        (active && !load) |-> cur_addr[`ADDR_W-1:2] == base_r)
        else $error("upper address moved in burst");
    AST_GLOBAL_ALL: assert property ( // R12
        @(posedge mclk) disable iff (!rstn)
        (wr_push && !in_r.allw_n) |-> wr_entry.lanes == 4'hF)
        else $error("global write missed a lane");
    AST_PROC_WINS: assert property ( // R21
        @(posedge mclk) disable iff (!rstn)
        (!in_r.pstb_n && !in_r.cstb_n && !in_r.cs1_n && !zz2_r)
            |-> pstrobe && !cstrobe && !wcycle)
        else $error("controller strobe acted with processor strobe");
    AST_CSTROBE_WR: assert property ( // R13
        @(posedge mclk) disable iff (!rstn)
        (cstrobe && selected && !in_r.allw_n && wbuf_ready)
            |-> wr_push && !rd_op)
        else $error("controller write not taken in one cycle");
    AST_SLEEP_IN: assert property ( // R18
        @(posedge mclk) disable iff (!rstn)
        sleep_request [*3] |=> sleeping)
        else $error("sleep not entered within two cycles");
    AST_PROC_FIRST: assert property ( // R9
        @(posedge mclk) disable iff (!rstn)
        (pstrobe && selected) |-> !wcycle && !wr_push && rd_op)
        else $error("write taken in first processor cycle");
    AST_DEPTH_DESEL: assert property ( // R22
        @(posedge mclk) disable iff (!rstn)
        (load && !in_r.cs2) |-> deselect && !rd_op && !wcycle)
        else $error("access started with depth select off");
    AST_LINEAR_WRAP: assert property ( // R4
        @(posedge mclk) disable iff (!rstn)
        (active && !load && in_r.order == 1'b0 && start_r == 2'h3
            && cur_beat == 2'h1) |-> cur_addr[1:0] == 2'h0)
        else $error("linear burst did not wrap");
endmodule : burst_sram_port

// File: pipelined_burst_sram_port_test.sv
`include "burst_sram_consts.svh"
module pipelined_burst_sram_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    mclk;
    logic                    rstn;
    logic                    sleep_request;
    logic                    oe_n;
    logic                    data_io_oe;
    logic                    wbuf_ready;
    logic                    sleeping;
    logic                    oe_seen;
    logic [`DATA_W-1:0]      wire_data;
    logic [`DATA_W-1:0]      data_io_in;
    logic [`DATA_W-1:0]      data_io_out;
    logic [`DATA_W-1:0]      q [4];
    burst_sram_pkg::bus_in_s bus;
    int                      failures;
    int                      n_tests;

    assign data_io_in = data_io_oe ? data_io_out : wire_data;
    always #20 mclk = ~mclk;

    burst_sram_port i_burst_sram_port (
        .mclk(mclk), .rstn(rstn), .addr(bus.addr),
        .data_io_in(data_io_in), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe),
        .processor_addr_strobe_n(bus.pstb_n),
        .controller_addr_strobe_n(bus.cstb_n),
        .burst_advance_n(bus.step_n), .global_write_n(bus.allw_n),
        .byte_write_enable_n(bus.bytew_n),
        .byte_lane_write_n(bus.lanew_n),
        .chip_select_primary_n(bus.cs1_n),
        .chip_select_depth_hi(bus.cs2),
        .chip_select_depth_lo_n(bus.cs3_n),
        .burst_order_sel(bus.order), .output_enable_n(oe_n),
        .sleep_request(sleep_request), .wbuf_ready(wbuf_ready),
        .sleeping(sleeping)
    );
    sram_master_model i_sram_master_model (
        .mclk(mclk), .rdata(data_io_out), .oe(data_io_oe), .bus(bus),
        .output_enable_n(oe_n), .wire_data(wire_data)
    );

    function automatic logic [`DATA_W-1:0] pat(input logic [`ADDR_W-1:0] a);
        return {a, ~a};
    endfunction : pat
    task automatic check(input logic [`DATA_W-1:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check
    task automatic rd1(input logic [`ADDR_W-1:0] a, input logic [35:0] e);
        i_sram_master_model.rd(a, 1'b0, 1, q, oe_seen);
        check(q[0], e, "read data");
        check({35'h0, oe_seen}, 36'h1, "read drive");
    endtask : rd1
    task automatic t_global();
        logic [`ADDR_W-1:0] a;
        for (int i = 0; i < 4; i++) begin
            a = 18'h100 | 18'(i);
            i_sram_master_model.wr(a, 0, 0, 0, 1, 4'hF, pat(a));
        end
        i_sram_master_model.wr(18'h200, 0, 0, 0, 1, 4'hF, pat(18'h200));
        i_sram_master_model.wr(18'h300, 0, 0, 0, 1, 4'hF, pat(18'h300));
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            a = 18'h100 | 18'(i);
            rd1(a, pat(a));
        end
    endtask : t_global
    task automatic t_burst();
        logic [1:0]         lo;
        logic [`DATA_W-1:0] e;
        for (int o = 0; o < 2; o++) begin
            i_sram_master_model.set_order(o[0]);
            for (int s = 1; s < 3; s++) begin
                i_sram_master_model.rd(18'h100 | 18'(s), o[0], 4, q,
                                       oe_seen);
                for (int k = 0; k < 4; k++) begin
                    lo = o[0] ? 2'(s ^ k) : 2'(s + k);
                    e = pat(18'h100 | 18'(lo));
                    check(q[k], e, "b");
                end
            end
        end
    endtask : t_burst
    task automatic t_bytes();
        i_sram_master_model.wr(18'h200, 1, 0, 1, 0, 4'hA, 36'hF_FFFF_FFFF);
        repeat (8) @(posedge mclk);
        rd1(18'h200, pat(18'h200) | 36'h0_07FC_01FF);
        i_sram_master_model.wr(18'h200, 0, 0, 1, 1, 4'h0, 36'h0);
        repeat (8) @(posedge mclk);
        rd1(18'h200, pat(18'h200) | 36'h0_07FC_01FF);
        i_sram_master_model.wr(18'h200, 0, 0, 0, 1, 4'hF, 36'h1_2345_6789);
        repeat (8) @(posedge mclk);
        rd1(18'h200, 36'h1_2345_6789);
        i_sram_master_model.wr(18'h300, 1, 1, 1, 1, 4'hF, 36'h0);
        repeat (8) @(posedge mclk);
        rd1(18'h300, pat(18'h300));
    endtask : t_bytes
    task automatic t_sleep();
        int n;
        rd1(18'h101, pat(18'h101));
        i_sram_master_model.desel();
        @(posedge mclk);
        check({35'h0, data_io_oe}, 36'h0, "deselect drive");
        sleep_request <= 1'b1;
        for (n = 1; n < 6 && sleeping !== 1'b1; n++) @(posedge mclk);
        check({35'h0, sleeping}, 36'h1, "sleep entry");
        check({35'h0, data_io_oe}, 36'h0, "sleep drive");
        sleep_request <= 1'b0;
        for (n = 1; n < 6 && sleeping !== 1'b0; n++) @(posedge mclk);
        check({35'h0, sleeping}, 36'h0, "sleep exit");
        repeat (3) @(posedge mclk);
        rd1(18'h101, pat(18'h101));
    endtask : t_sleep
    task automatic stop_test();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        #800000;
        failures++;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        sleep_request = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        check({34'h0, wbuf_ready, sleeping}, 36'h2, "reset state");
        t_global();
        t_burst();
        t_bytes();
        t_sleep();
        stop_test();
    end
endmodule : pipelined_burst_sram_port_test

// File: sram_master_model.sv
`include "burst_sram_consts.svh"
module sram_master_model (
    input  wire logic                 mclk,
    input  wire logic [`DATA_W-1:0]   rdata,
    input  wire logic                 oe,
    output burst_sram_pkg::bus_in_s   bus,
    output logic                      output_enable_n,
    output logic      [`DATA_W-1:0]   wire_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic               drv;
    logic [`DATA_W-1:0] noise;
    initial begin
        bus = '0;
        bus.pstb_n = 1'b1;
        bus.cstb_n = 1'b1;
        bus.step_n = 1'b1;
        bus.allw_n = 1'b1;
        bus.bytew_n = 1'b1;
        bus.lanew_n = `LANES_ALL;
        bus.cs2 = 1'b1;
        bus.order = 1'b1;
        output_enable_n = 1'b1;
        drv = 1'b0;
        noise = '0;
    end
    // Released lines show a changing pattern
    always @(posedge mclk) noise <= ~noise;
    assign wire_data = drv ? bus.data : noise;
    task automatic set_oe(input logic n);
        if (output_enable_n !== n) begin
            @(posedge mclk);
            output_enable_n <= n;
            repeat (3) @(posedge mclk);
        end
    endtask : set_oe
    task automatic set_order(input logic o);
        @(posedge mclk);
        bus.order <= o;
    endtask : set_order
    task automatic rd(input logic [`ADDR_W-1:0] a, input logic use_p,
                      input int beats, output logic [`DATA_W-1:0] q [4],
                      output logic oe_seen);
        set_oe(1'b0);
        @(posedge mclk);
        bus.pstb_n <= ~use_p;
        bus.cstb_n <= use_p;
        bus.cs1_n <= 1'b0;
        bus.addr <= a;
        @(posedge mclk);
        bus.pstb_n <= 1'b1;
        bus.cstb_n <= 1'b1;
        bus.step_n <= (beats > 1) ? 1'b0 : 1'b1;
        bus.cs2 <= 1'b0;
        for (int k = 0; k <= beats; k++) begin
            @(posedge mclk);
            if (k > 0) q[k-1] = rdata;
            if (k == beats) oe_seen = oe;
            if (k == beats - 2) bus.step_n <= 1'b1;
        end
        bus.cs2 <= 1'b1;
    endtask : rd
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic use_p,
                      input logic both, input logic allw_n,
                      input logic bytew_n,
                      input logic [`LANES-1:0] lanew_n,
                      input logic [`DATA_W-1:0] d);
        set_oe(1'b1);
        @(posedge mclk);
        bus.pstb_n <= ~use_p;
        bus.cstb_n <= use_p & ~both;
        bus.cs1_n <= 1'b0;
        bus.addr <= a;
        bus.allw_n <= use_p ? 1'b0 : allw_n;
        bus.bytew_n <= use_p ? 1'b0 : bytew_n;
        bus.lanew_n <= use_p ? `LANES_NONE : lanew_n;
        bus.data <= use_p ? ~d : d;
        drv <= 1'b1;
        if (use_p) begin
            @(posedge mclk);
            bus.pstb_n <= 1'b1;
            bus.cstb_n <= 1'b1;
            bus.allw_n <= allw_n;
            bus.bytew_n <= bytew_n;
            bus.lanew_n <= lanew_n;
            bus.data <= d;
        end
        @(posedge mclk);
        bus.pstb_n <= 1'b1;
        bus.cstb_n <= 1'b1;
        bus.allw_n <= 1'b1;
        bus.bytew_n <= 1'b1;
        bus.lanew_n <= `LANES_ALL;
        drv <= 1'b0;
    endtask : wr
    // Deselect and keep the primary select inactive until the next access
    task automatic desel();
        @(posedge mclk);
        bus.cstb_n <= 1'b0;
        bus.cs1_n <= 1'b1;
        @(posedge mclk);
        bus.cstb_n <= 1'b1;
    endtask : desel
endmodule : sram_master_model
